// ==== src/mcuide_core.sv ====
// Instruction decode and execution core of an 8-bit Harvard controller, with 256 bytes of RAM.
// Assumes asynchronous-read program memory and I/O read data on the same clock.
//
// What this block does
// - Push lowers the data stack pointer first, then writes RAM at the new pointer.
// - Pop reads RAM at the data stack pointer, then raises the pointer.
// - Reset zeroes the data stack pointer; push from zero lands at 0xff.
// - Immediate mode takes the second instruction byte as the operand value.
// - Direct mode takes the second byte as a RAM address of the operand.
// - Indexed mode address is second byte plus index register, eight bits.
// - Flag-conditional jumps last five cycles when taken, four when not.
// - Accumulator ALU triples 01-15 take 4/6/7 cycles; compare 16-18 takes 5/7/8.
// - Load accumulator 19-1B takes 4/5/6; load index 1C/1D takes 4/5; 1E reserved.
// - Index and accumulator moves 40, 41 and stack-pointer load 60 take 4 cycles.
// - Increment 21-24 and decrement 25-28 take 4, 4, 7 and 8 cycles.
// - Port read 29 and port write 2A take 5 cycles; indexed port write 39 takes 6.
// - Pops 2B/2C take 4; pushes 2D/2E and swaps 2F/30 take 5 cycles.
// - Store 31/32 take 5/6; read-modify-write 33-38 take 7 direct, 8 indexed.
// - Jump 8x takes 5, call 5x or 9x takes 10; conditionals occupy Ax to Dx.
// - Accumulator jump Ex takes 7 cycles; table lookup Fx takes 14 cycles.
// - Data memory holds 256 bytes reached by 8-bit addresses.
// - Reset clears the 14-bit program counter so fetching starts at 0x0000.
// - Sequential fetch advances only the low byte; page advance raises the upper six bits.
// - Interrupt acknowledge and call push counter and flags as two bytes, disabling on ack.
// - Return restores counter only, pointer minus two; interrupt return restores flags too.
`timescale 1ns/1ns
`include "mcuide_map.svh"
module mcuide_core (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic irq,
   input wire logic [7:0] prog_data,
   input wire logic [7:0] io_rdata,
   output logic [13:0] prog_addr,
   output mcuide_pkg::mcuide_io_t io_bus,
   output logic irq_ack,
   output logic halted,
   output logic [7:0] acc_out
);
   import mcuide_pkg::*;

   function automatic logic [8:0] alu_fn(input logic [2:0] grp, input logic [7:0] a,
                                          input logic [7:0] b, input logic cin);
      logic [8:0] r;
      r = 9'h000;
      unique case (grp)
         3'd0: r = {1'b0, a} + {1'b0, b};
         3'd1: r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         3'd2, 3'd7: r = {1'b0, a} - {1'b0, b};
         3'd3: r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
         3'd4: r = {1'b0, a | b};
         3'd5: r = {1'b0, a & b};
         default: r = {1'b0, a ^ b};
      endcase
      return r;
   endfunction

   function automatic logic [3:0] cyc_fn(input logic [7:0] op, input logic taken);
      logic [7:0] k;
      logic [3:0] c;
      k = (op - `OP_ALU_FIRST) % 8'h03;
      c = `CYC_BASIC;
      if (op >= `OP_ALU_FIRST && op <= `OP_ALU_LAST) begin
         if (((op - `OP_ALU_FIRST) / 8'h03) == 8'(`GRP_CMP))
            c = (k == 8'h00) ? `CYC_CMP_IMM : (k == 8'h01) ? `CYC_CMP_DIR : `CYC_CMP_IDX;
         else
            c = (k == 8'h00) ? `CYC_BASIC : (k == 8'h01) ? `CYC_ALU_DIR : `CYC_ALU_IDX;
      end else if (op[7:4] >= `NIB_CALL_LO && op != `OP_MOV_PSPA && op[7:4] != 4'h7) begin
         case (op[7:4])
            `NIB_CALL_LO, `NIB_CALL_HI: c = `CYC_CALL;
            `NIB_JMP: c = `CYC_JMP;
            `NIB_ACCJMP: c = `CYC_ACCJMP;
            `NIB_INDEX: c = `CYC_INDEX;
            default: c = taken ? `CYC_JCC_TAKEN : `CYC_JCC_FALL;
         endcase
      end else begin
         case (op)
            `OP_HALT: c = `CYC_HALT;
            `OP_LDA_DIR, `OP_LDX_DIR: c = `CYC_LD_DIR;
            `OP_LDA_IDX: c = `CYC_LD_IDX;
            `OP_INC_DIR, `OP_DEC_DIR: c = `CYC_MEM_DIR;
            `OP_INC_IDX, `OP_DEC_IDX: c = `CYC_MEM_IDX;
            `OP_IO_RD, `OP_IO_WR: c = `CYC_IO;
            `OP_IO_WRX: c = `CYC_IO_WRITE_INDEXED_INSTR;
            `OP_PUSH_A, `OP_PUSH_X, `OP_SWAP_AX, `OP_SWAP_ADSP: c = `CYC_STACK;
            `OP_STA_DIR: c = `CYC_LD_DIR;
            `OP_STA_IDX: c = `CYC_LD_IDX;
            8'h33, 8'h35, 8'h37: c = `CYC_MEM_DIR;
            8'h34, 8'h36, 8'h38: c = `CYC_MEM_IDX;
            `OP_RET, `OP_IRET: c = `CYC_RET;
            default: c = `CYC_BASIC;
         endcase
      end
      return c;
   endfunction

   function automatic logic one_byte_fn(input logic [7:0] op);
      return (op == `OP_HALT) || (op >= `OP_PAGE_ADV && op <= `OP_INC_X)
         || op == `OP_DEC_A || op == `OP_DEC_X || (op >= `OP_POP_A && op <= `OP_SWAP_ADSP)
         || (op >= `OP_COMPL && op <= `OP_MOV_XA) || op == `OP_MOV_PSPA
         || (op >= `OP_INT_DIS && op <= `OP_IRET);
   endfunction

   logic [7:0] ram [0:255];
   logic [13:0] pc_reg;
   logic [7:0] a_reg, x_reg, dsp_reg, pstk_reg, op_reg, arg_reg;
   logic c_reg, z_reg, ie_reg, ack_reg, irq_meta_reg, irq_sync_reg;
   logic [3:0] cnt_reg;
   mcuide_state_t st_reg;

   wire run = (st_reg == ST_RUN);
   wire [3:0] ncyc;
   wire cnd_taken = (op_reg[7:4] == `NIB_JMPZ && z_reg) || (op_reg[7:4] == `NIB_JMPNZ && !z_reg)
      || (op_reg[7:4] == `NIB_JMPC && c_reg) || (op_reg[7:4] == `NIB_JMPNC && !c_reg);
   wire is_jcc = op_reg[7:4] >= `NIB_JMPZ && op_reg[7:4] <= `NIB_JMPNC;
   assign ncyc = ack_reg ? `CYC_IRQ_ACK : cyc_fn(op_reg, cnd_taken);
   wire last = run && cnt_reg == ncyc;
   wire exec = run && !ack_reg && cnt_reg == `CNT_EXEC;
   wire ack_exec = run && ack_reg && cnt_reg == `CNT_EXEC;
   wire late = run && !ack_reg && cnt_reg == `CNT_LATE;

   wire in_alu = op_reg >= `OP_ALU_FIRST && op_reg <= `OP_ALU_LAST;
   wire [7:0] alu_k = (op_reg - `OP_ALU_FIRST) % 8'h03;
   wire [2:0] alu_grp = 3'((op_reg - `OP_ALU_FIRST) / 8'h03);
   wire is_idx = (in_alu && alu_k == 8'h02) || op_reg == `OP_LDA_IDX || op_reg == `OP_INC_IDX
      || op_reg == `OP_DEC_IDX || op_reg == `OP_STA_IDX || op_reg == 8'h34 || op_reg == 8'h36
      || op_reg == 8'h38 || op_reg == `OP_IO_WRX;
   wire is_imm = (in_alu && alu_k == 8'h00) || op_reg == `OP_LDA_IMM || op_reg == `OP_LDX_IMM;
   wire [7:0] ea = is_idx ? 8'(arg_reg + x_reg) : arg_reg;
   wire [7:0] ram_ea = ram[ea];
   wire [7:0] opnd = is_imm ? arg_reg : ram_ea;
   wire [8:0] alu_res = alu_fn(alu_grp, a_reg, opnd, c_reg);
   wire [2:0] rmw_grp = 3'd4 + 3'((op_reg - `OP_RMW_FIRST) >> 1);
   wire [8:0] rmw_res = alu_fn(rmw_grp, ram_ea, a_reg, c_reg);
   wire is_rmw = op_reg >= `OP_RMW_FIRST && op_reg <= `OP_RMW_LAST;
   wire is_dec = op_reg >= `OP_DEC_A && op_reg <= `OP_DEC_IDX;
   wire [7:0] idc_in = (op_reg == `OP_INC_A || op_reg == `OP_DEC_A) ? a_reg
      : (op_reg == `OP_INC_X || op_reg == `OP_DEC_X) ? x_reg : ram_ea;
   wire [8:0] idc_res = is_dec ? {1'b0, idc_in} - 9'h001 : {1'b0, idc_in} + 9'h001;
   wire [7:0] dsp_dn = dsp_reg - 8'h01;
   wire [7:0] pstk_up = pstk_reg + 8'h01;
   wire [7:0] pstk_m1 = pstk_reg - 8'h01;
   wire [7:0] pstk_m2 = pstk_reg - 8'h02;
   wire [7:0] len = one_byte_fn(op_reg) ? 8'h01 : 8'h02;
   wire [13:0] seq_pc = {pc_reg[13:8], 8'(pc_reg[7:0] + len)};
   wire [11:0] target = {op_reg[3:0], arg_reg};
   wire [13:0] jmp_pc = {pc_reg[13:12], target};
   wire [13:0] accjmp_pc = {pc_reg[13:12], 12'(target + {4'h0, a_reg})};
   wire do_call = op_reg[7:4] == `NIB_CALL_LO || op_reg[7:4] == `NIB_CALL_HI;

   always_ff @(posedge clk) begin
      irq_meta_reg <= sys_rst ? 1'b0 : irq;
      irq_sync_reg <= sys_rst ? 1'b0 : irq_meta_reg;
   end

   always_ff @(posedge clk) begin
      io_bus.wr <= 1'b0;
      io_bus.rd <= 1'b0;
      irq_ack <= 1'b0;
      if (sys_rst) begin
         pc_reg <= `RST_PC;
         prog_addr <= `RST_PC;
         dsp_reg <= `RST_BYTE;
         pstk_reg <= `RST_BYTE;
         a_reg <= `RST_BYTE;
         x_reg <= `RST_BYTE;
         op_reg <= `RST_BYTE;
         arg_reg <= `RST_BYTE;
         {c_reg, z_reg, ie_reg, ack_reg} <= 4'h0;
         cnt_reg <= `CNT_FIRST;
         st_reg <= ST_RUN;
         io_bus.addr <= `RST_BYTE;
         io_bus.wdata <= `RST_BYTE;
      end else if (run) begin
         cnt_reg <= last ? `CNT_FIRST : cnt_reg + 4'h1;
         if (cnt_reg == `CNT_FIRST && !ack_reg) begin
            op_reg <= prog_data;
            prog_addr <= {pc_reg[13:8], 8'(pc_reg[7:0] + 8'h01)};
         end
         if (cnt_reg == 4'd2 && !ack_reg)
            arg_reg <= prog_data;
         if (ack_exec) begin
            ram[pstk_reg] <= pc_reg[7:0];
            ram[pstk_up] <= {c_reg, z_reg, pc_reg[13:8]};
            pstk_reg <= pstk_reg + 8'h02;
            ie_reg <= 1'b0;
            pc_reg <= `IRQ_VECTOR;
            irq_ack <= 1'b1;
         end
         if (exec) begin
            pc_reg <= seq_pc;
            if (in_alu) begin
               if (alu_grp != `GRP_CMP)
                  a_reg <= alu_res[7:0];
               c_reg <= alu_res[8];
               z_reg <= alu_res[7:0] == 8'h00;
            end else if (is_rmw) begin
               ram[ea] <= rmw_res[7:0];
               z_reg <= rmw_res[7:0] == 8'h00;
            end else if (op_reg >= `OP_INC_A && op_reg <= `OP_DEC_IDX) begin
               c_reg <= idc_res[8];
               z_reg <= idc_res[7:0] == 8'h00;
               if (op_reg == `OP_INC_A || op_reg == `OP_DEC_A)
                  a_reg <= idc_res[7:0];
               else if (op_reg == `OP_INC_X || op_reg == `OP_DEC_X)
                  x_reg <= idc_res[7:0];
               else
                  ram[ea] <= idc_res[7:0];
            end else begin
               case (op_reg)
                  `OP_LDA_IMM, `OP_LDA_DIR, `OP_LDA_IDX: a_reg <= opnd;
                  `OP_LDX_IMM, `OP_LDX_DIR: x_reg <= opnd;
                  `OP_PAGE_ADV: pc_reg <= {6'(pc_reg[13:8] + 6'h01), 8'(pc_reg[7:0] + 8'h01)};
                  `OP_IO_RD: begin
                     io_bus.addr <= arg_reg;
                     io_bus.rd <= 1'b1;
                  end
                  `OP_IO_WR, `OP_IO_WRX: begin
                     io_bus.addr <= ea;
                     io_bus.wdata <= a_reg;
                     io_bus.wr <= 1'b1;
                  end
                  `OP_POP_A, `OP_POP_X: begin
                     if (op_reg == `OP_POP_A)
                        a_reg <= ram[dsp_reg];
                     else
                        x_reg <= ram[dsp_reg];
                     dsp_reg <= dsp_reg + 8'h01;
                  end
                  `OP_PUSH_A, `OP_PUSH_X: begin
                     dsp_reg <= dsp_dn;
                     ram[dsp_dn] <= (op_reg == `OP_PUSH_A) ? a_reg : x_reg;
                  end
                  `OP_SWAP_AX: {a_reg, x_reg} <= {x_reg, a_reg};
                  `OP_SWAP_ADSP: {a_reg, dsp_reg} <= {dsp_reg, a_reg};
                  `OP_STA_DIR, `OP_STA_IDX: ram[ea] <= a_reg;
                  `OP_COMPL: begin
                     a_reg <= ~a_reg;
                     z_reg <= a_reg == 8'hff;
                  end
                  `OP_SHL: {c_reg, a_reg} <= {a_reg, 1'b0};
                  `OP_SHR: {a_reg, c_reg} <= {a_reg[7], a_reg};
                  `OP_ROL: {c_reg, a_reg} <= {a_reg, c_reg};
                  `OP_ROR: {a_reg, c_reg} <= {c_reg, a_reg};
                  `OP_RET, `OP_IRET: begin
                     pc_reg <= {ram[pstk_m1][5:0], ram[pstk_m2]};
                     pstk_reg <= pstk_m2;
                     if (op_reg == `OP_IRET) begin
                        {c_reg, z_reg} <= ram[pstk_m1][7:6];
                        ie_reg <= 1'b1;
                     end
                  end
                  `OP_MOV_AX: a_reg <= x_reg;
                  `OP_MOV_XA: x_reg <= a_reg;
                  `OP_MOV_PSPA: pstk_reg <= a_reg;
                  `OP_INT_DIS: ie_reg <= 1'b0;
                  `OP_INT_EN: ie_reg <= 1'b1;
                  default: begin
                     if (do_call) begin
                        ram[pstk_reg] <= seq_pc[7:0];
                        ram[pstk_up] <= {c_reg, z_reg, seq_pc[13:8]};
                        pstk_reg <= pstk_reg + 8'h02;
                        pc_reg <= jmp_pc;
                     end else if (op_reg[7:4] == `NIB_JMP || (is_jcc && cnd_taken))
                        pc_reg <= jmp_pc;
                     else if (op_reg[7:4] == `NIB_ACCJMP)
                        pc_reg <= accjmp_pc;
                     else if (op_reg[7:4] == `NIB_INDEX)
                        prog_addr <= accjmp_pc;
                  end
               endcase
            end
         end
         if (late && op_reg == `OP_IO_RD)
            a_reg <= io_rdata;
         if (late && op_reg[7:4] == `NIB_INDEX && !one_byte_fn(op_reg))
            a_reg <= prog_data;
         if (last) begin
            prog_addr <= pc_reg;
            ack_reg <= !ack_reg && op_reg != `OP_HALT && irq_sync_reg && ie_reg;
            if (!ack_reg && op_reg == `OP_HALT)
               st_reg <= ST_HALT;
         end
      end
   end

   always_ff @(posedge clk)
      halted <= !sys_rst && st_reg == ST_HALT;

   assign acc_out = a_reg;

   property p_push;
      @(posedge clk) disable iff (sys_rst)
      exec && op_reg == `OP_PUSH_A |=> dsp_reg == $past(dsp_reg) - 8'h01
         && ram[dsp_reg] == $past(a_reg);
   endproperty
   a_push: assert property (p_push) else $error("push order wrong");
   property p_pop;
      @(posedge clk) disable iff (sys_rst)
      exec && op_reg == `OP_POP_X |=> x_reg == ram[$past(dsp_reg)]
         && dsp_reg == $past(dsp_reg) + 8'h01;
   endproperty
   a_pop: assert property (p_pop) else $error("pop order wrong");
   property p_rst_clear;
      @(posedge clk) $past(sys_rst) |-> dsp_reg == 8'h00 && prog_addr == 14'h0000;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("reset did not clear");
   property p_jcc_time;
      @(posedge clk) disable iff (sys_rst)
      last && !ack_reg && is_jcc |-> $past(cnt_reg, 3) == (cnd_taken ? 4'd2 : 4'd1);
   endproperty
   a_jcc_time: assert property (p_jcc_time) else $error("conditional jump length");
   property p_idx_load;
      @(posedge clk) disable iff (sys_rst)
      exec && op_reg == `OP_LDA_IDX |=> a_reg == ram[8'($past(arg_reg) + $past(x_reg))];
   endproperty
   a_idx_load: assert property (p_idx_load) else $error("indexed load wrong");
   property p_call;
      @(posedge clk) disable iff (sys_rst)
      exec && do_call |=> pstk_reg == $past(pstk_reg) + 8'h02 ##6 last;
   endproperty
   a_call: assert property (p_call) else $error("call push or length wrong");
   property p_ret;
      @(posedge clk) disable iff (sys_rst)
      exec && op_reg == `OP_RET |=> pstk_reg == $past(pstk_reg) - 8'h02
         && c_reg == $past(c_reg) && z_reg == $past(z_reg) ##4 last;
   endproperty
   a_ret: assert property (p_ret) else $error("return wrong");
   property p_page;
      @(posedge clk) disable iff (sys_rst)
      exec && op_reg == `OP_INC_A |=> pc_reg[13:8] == $past(pc_reg[13:8]);
   endproperty
   a_page: assert property (p_page) else $error("upper counter moved");
   property p_alu_dir;
      @(posedge clk) disable iff (sys_rst)
      last && !ack_reg && op_reg == 8'h02 |-> $past(cnt_reg, 5) == 4'd1;
   endproperty
   a_alu_dir: assert property (p_alu_dir) else $error("direct add length");
   c_taken: cover property (@(posedge clk) exec && is_jcc && cnd_taken);
   c_push: cover property (@(posedge clk) exec && op_reg == `OP_PUSH_A && dsp_reg == 8'h00);
   c_call: cover property (@(posedge clk) exec && do_call);
   c_irq: cover property (@(posedge clk) irq_ack);
endmodule // mcuide_core

// ==== include/mcuide_map.svh ====
// Opcodes, cycle counts and reset values of the instruction decode and execute core.
// Assumes nothing beyond being included by the core.
`ifndef MCUIDE_MAP_SVH
`define MCUIDE_MAP_SVH
`define OP_HALT 8'h00
`define OP_ALU_FIRST 8'h01
`define OP_ALU_LAST 8'h18
`define OP_LDA_IMM 8'h19
`define OP_LDA_DIR 8'h1a
`define OP_LDA_IDX 8'h1b
`define OP_LDX_IMM 8'h1c
`define OP_LDX_DIR 8'h1d
`define OP_PAGE_ADV 8'h1f
`define OP_INC_A 8'h21
`define OP_INC_X 8'h22
`define OP_INC_DIR 8'h23
`define OP_INC_IDX 8'h24
`define OP_DEC_A 8'h25
`define OP_DEC_X 8'h26
`define OP_DEC_DIR 8'h27
`define OP_DEC_IDX 8'h28
`define OP_IO_RD 8'h29
`define OP_IO_WR 8'h2a
`define OP_POP_A 8'h2b
`define OP_POP_X 8'h2c
`define OP_PUSH_A 8'h2d
`define OP_PUSH_X 8'h2e
`define OP_SWAP_AX 8'h2f
`define OP_SWAP_ADSP 8'h30
`define OP_STA_DIR 8'h31
`define OP_STA_IDX 8'h32
`define OP_RMW_FIRST 8'h33
`define OP_RMW_LAST 8'h38
`define OP_IO_WRX 8'h39
`define OP_COMPL 8'h3a
`define OP_SHL 8'h3b
`define OP_SHR 8'h3c
`define OP_ROL 8'h3d
`define OP_ROR 8'h3e
`define OP_RET 8'h3f
`define OP_MOV_AX 8'h40
`define OP_MOV_XA 8'h41
`define OP_MOV_PSPA 8'h60
`define OP_INT_DIS 8'h70
`define OP_INT_EN 8'h72
`define OP_IRET 8'h73
`define NIB_CALL_LO 4'h5
`define NIB_JMP 4'h8
`define NIB_CALL_HI 4'h9
`define NIB_JMPZ 4'ha
`define NIB_JMPNZ 4'hb
`define NIB_JMPC 4'hc
`define NIB_JMPNC 4'hd
`define NIB_ACCJMP 4'he
`define NIB_INDEX 4'hf
`define GRP_CMP 3'd7
`define CYC_BASIC 4'd4
`define CYC_ALU_DIR 4'd6
`define CYC_ALU_IDX 4'd7
`define CYC_CMP_IMM 4'd5
`define CYC_CMP_DIR 4'd7
`define CYC_CMP_IDX 4'd8
`define CYC_LD_DIR 4'd5
`define CYC_LD_IDX 4'd6
`define CYC_MEM_DIR 4'd7
`define CYC_MEM_IDX 4'd8
`define CYC_IO 4'd5
`define CYC_IO_WRITE_INDEXED_INSTR 4'd6
`define CYC_STACK 4'd5
`define CYC_HALT 4'd7
`define CYC_RET 4'd8
`define CYC_JMP 4'd5
`define CYC_JCC_TAKEN 4'd5
`define CYC_JCC_FALL 4'd4
`define CYC_CALL 4'd10
`define CYC_ACCJMP 4'd7
`define CYC_INDEX 4'd14
`define CYC_IRQ_ACK 4'd10
`define CNT_FIRST 4'd1
`define CNT_EXEC 4'd3
`define CNT_LATE 4'd4
`define IRQ_VECTOR 14'h0008
`define RST_PC 14'h0000
`define RST_BYTE 8'h00
`endif

// ==== include/mcuide_pkg.sv ====
// Types of the instruction decode and execute core.
// Assumes nothing of its surroundings.
package mcuide_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mcuide_io_t;
   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_HALT = 2'b10
   } mcuide_state_t;
endpackage

// ==== bench/mcuide_mem_model.sv ====
// Program memory and I/O register space facing the decode and execute core.
// Assumes one clock; rom is loaded by the bench through a hierarchical path.
`timescale 1ns/1ns
module mcuide_mem_model (
   input wire logic clk,
   input wire logic [13:0] prog_addr,
   input wire mcuide_pkg::mcuide_io_t io_bus,
   output logic [7:0] prog_data,
   output logic [7:0] io_rdata
);
   import mcuide_pkg::*;
   logic [7:0] rom [0:511];
   logic [7:0] junk_reg = 8'h3c;
   // Changing pattern where nothing is driven, so a stale value never passes
   always_ff @(posedge clk) begin
      junk_reg <= ~junk_reg + 8'h01;
   end
   assign prog_data = (prog_addr[13:9] == 5'h00) ? rom[prog_addr[8:0]] : junk_reg;
   // Port read answers while the read strobe stands
   assign io_rdata = (io_bus.rd === 1'b1) ? (io_bus.addr ^ 8'ha5) : junk_reg;
endmodule // mcuide_mem_model

// ==== bench/mcu8_instruction_decode_exec_test.sv ====
// Self-checking bench: one table of single-instruction programs, then hand-written programs.
// Assumes mcuide_pkg, mcuide_core and mcuide_mem_model are compiled first.
`timescale 1ns/1ns
module mcu8_instruction_decode_exec_test;
   import mcuide_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic irq = 1'b0;
   logic [7:0] prog_data;
   logic [7:0] io_rdata;
   logic [13:0] prog_addr;
   mcuide_io_t io_bus;
   logic irq_ack;
   logic halted;
   logic [7:0] acc_out;
   int errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int nw = 0;
   int n_ack = 0;
   bit irq_arm = 1'b0;
   int wc [4];
   logic [7:0] wd [4];
   logic [7:0] wa [4];
   logic [7:0] prg [$];
   // Row: opcode, operand, preset accumulator, expected accumulator, cycles
   logic [35:0] rows [$] = {
      36'h01_05_10_15_4, 36'h02_13_10_6c_6, 36'h03_10_10_6c_7, 36'h04_05_10_15_4,
      36'h05_13_10_6c_6, 36'h06_10_10_6c_7, 36'h07_05_10_0b_4, 36'h08_13_10_b4_6,
      36'h09_10_10_b4_7, 36'h0a_05_10_0b_4, 36'h0b_13_10_b4_6, 36'h0c_10_10_b4_7,
      36'h0d_01_10_11_4, 36'h0e_13_10_5c_6, 36'h0f_10_10_5c_7, 36'h10_30_10_10_4,
      36'h11_13_10_10_6, 36'h12_10_10_10_7, 36'h13_ff_10_ef_4, 36'h14_13_10_4c_6,
      36'h15_10_10_4c_7, 36'h16_10_10_10_5, 36'h17_13_10_10_7, 36'h18_10_10_10_8,
      36'h19_77_10_77_4, 36'h1a_13_10_5c_5, 36'h1b_10_10_5c_6, 36'h1c_07_10_10_4,
      36'h1d_13_10_10_5, 36'h1e_00_10_10_4, 36'h21_00_10_11_4, 36'h22_00_10_10_4,
      36'h23_13_10_10_7, 36'h24_10_10_10_8, 36'h25_00_10_0f_4, 36'h26_00_10_10_4,
      36'h27_13_10_10_7, 36'h28_10_10_10_8, 36'h29_07_10_a2_5, 36'h2f_00_10_03_5,
      36'h30_00_10_00_5, 36'h31_20_10_10_5, 36'h32_20_10_10_6, 36'h33_20_10_10_7,
      36'h34_20_10_10_8, 36'h35_20_10_10_7, 36'h36_20_10_10_8, 36'h37_20_10_10_7,
      36'h38_20_10_10_8, 36'h3a_00_10_ef_4, 36'h3b_00_10_20_4, 36'h3c_00_10_08_4,
      36'h3d_00_10_20_4, 36'h3e_00_10_08_4, 36'h40_00_10_03_4, 36'h41_00_10_10_4,
      36'h60_00_10_10_4, 36'h70_00_10_10_4, 36'h72_00_10_10_4, 36'h80_0c_10_10_5,
      36'h50_0c_10_10_a, 36'h90_0c_10_10_a, 36'hc0_0c_10_10_4, 36'hd0_0c_10_10_5,
      36'he0_0a_02_02_7, 36'hf0_0a_02_2a_e
   };

   mcuide_core i_mcuide_core (.clk(clk), .sys_rst(sys_rst), .irq(irq), .prog_data(prog_data),
      .io_rdata(io_rdata), .prog_addr(prog_addr), .io_bus(io_bus), .irq_ack(irq_ack),
      .halted(halted), .acc_out(acc_out));
   mcuide_mem_model i_mcuide_mem_model (.clk(clk), .prog_addr(prog_addr), .io_bus(io_bus),
      .prog_data(prog_data), .io_rdata(io_rdata));

   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   // Interrupt line: raised on request, dropped for good at the first acknowledge
   always @(posedge clk) begin
      if (irq_ack === 1'b1) n_ack <= n_ack + 1;
      irq <= irq_arm && n_ack == 0 && irq_ack !== 1'b1;
   end
   // Port write log: cycle, address and data of the first four write strobes
   always @(negedge clk) begin
      if (io_bus.wr === 1'b1 && nw < 4) begin
         wc[nw] = cyc;
         wd[nw] = io_bus.wdata;
         wa[nw] = io_bus.addr;
         nw = nw + 1;
      end
   end

   function automatic bit one_byte(input logic [7:0] o);
      return o == 8'h00 || (o >= 8'h1f && o <= 8'h22) || o == 8'h25 || o == 8'h26 ||
         (o >= 8'h2b && o <= 8'h30) || (o >= 8'h3a && o <= 8'h41) || o == 8'h60 ||
         (o >= 8'h70 && o <= 8'h73);
   endfunction

   task automatic chk(input bit ok, input string msg);
      n_compared++;
      if (!ok) begin
         errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   task automatic end_sim;
      if (errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic load;
      for (int i = 0; i < 512; i++) i_mcuide_mem_model.rom[i] = (i < prg.size()) ? prg[i] : 8'h00;
   endtask

   // Reset, run to halt, then judge the two port writes around the code under test
   task automatic run(input logic [7:0] exp_acc, input int dlt);
      int k;
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(prog_addr === 14'h0000 && acc_out === 8'h00 && halted === 1'b0, "reset state");
      nw = 0;
      @(posedge clk);
      sys_rst <= 1'b0;
      k = 0;
      while (halted !== 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
      end
      chk(k < 400, "no halt");
      chk(nw == 2 && wa[0] === 8'h00 && wa[1] === 8'h01, "port writes");
      chk(wd[1] === exp_acc && acc_out === exp_acc, "accumulator value");
      chk(wc[1] - wc[0] == dlt + 5, "cycle count");
   endtask

   initial begin
      logic [35:0] r;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         r = rows[i];
         prg = {8'h19, 8'h5c, 8'h31, 8'h13, 8'h19, r[19:12], 8'h1c, 8'h03, 8'h2a, 8'h00};
         prg.push_back(r[35:28]);
         if (!one_byte(r[35:28])) prg.push_back(r[27:20]);
         prg = {prg, 8'h2a, 8'h01, 8'h00};
         load();
         run(r[11:4], int'(r[3:0]));
      end
      // Push from pointer zero lands at the top byte
      prg = {8'h19, 8'h5a, 8'h2a, 8'h00, 8'h2d, 8'h19, 8'h66, 8'h2d, 8'h1a, 8'hff, 8'h2a, 8'h01};
      load();
      run(8'h5a, 19);
      // Two pops return the pushed bytes in reverse order
      prg = {8'h1c, 8'h5a, 8'h2e, 8'h19, 8'h66, 8'h2d, 8'h2a, 8'h00, 8'h2c, 8'h2b, 8'h2a, 8'h01};
      load();
      run(8'h5a, 8);
      // Equal compare: zero taken, nonzero and carry fall through, no-carry taken
      prg = {8'h19, 8'h10, 8'h2a, 8'h00, 8'h16, 8'h10, 8'ha0, 8'h08, 8'hb0, 8'h0a, 8'hc0, 8'h0c,
         8'hd0, 8'h0e, 8'h2a, 8'h01};
      load();
      run(8'h10, 23);
      // Call then return to the byte after the call
      prg = {8'h19, 8'h33, 8'h2a, 8'h00, 8'h50, 8'h0a, 8'h2a, 8'h01, 8'h00, 8'h00, 8'h3f};
      load();
      run(8'h33, 18);
      // Page advance moves fetching to the next 256-byte page
      prg = {8'h19, 8'h44, 8'h2a, 8'h00, 8'h1f};
      load();
      i_mcuide_mem_model.rom[9'h105] = 8'h2a;
      i_mcuide_mem_model.rom[9'h106] = 8'h01;
      run(8'h44, 4);
      // Indexed port write: address wraps to the constant plus the index register
      prg = {8'h19, 8'h66, 8'h2a, 8'h00, 8'h1c, 8'h04, 8'h39, 8'hfd};
      load();
      run(8'h66, 4);
      // Interrupt after enable, service routine, return restores the zero flag
      irq_arm = 1'b1;
      prg = {8'h16, 8'h00, 8'h72, 8'ha0, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h2a, 8'h00, 8'h21, 8'h73,
         8'h2a, 8'h01};
      load();
      run(8'h01, 17);
      chk(n_ack == 1, "interrupt acknowledge");
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      end_sim();
   end
endmodule // mcu8_instruction_decode_exec_test
